/* File: timer_output_mode_params.svh */
// constants for the timer output mode select block
// assumes the including file sits in the same folder
`ifndef TIMER_OUTPUT_MODE_PARAMS_SVH
`define TIMER_OUTPUT_MODE_PARAMS_SVH
`define TOM_UNIT0_ADDR     20'hf01be
`define TOM_UNIT0_ADDR_HI  20'hf01bf
`define TOM_UNIT1_ADDR     20'hf01e6
`define TOM_UNIT1_ADDR_HI  20'hf01e7
`define TOL_UNIT0_ADDR     20'hf01bc
`define TOL_UNIT1_ADDR     20'hf01e4
`define TOM_RESET          16'h0000
`define UNIT0_CHANNELS     8
`define UNIT1_CHANNELS     4
`define UNIT0_MASK         16'h00ff
`define UNIT1_MASK         16'h000f
`endif

/* File: timer_output_mode_pkg.sv */
// types for the timer output mode select block
// assumes timer_output_mode_params.svh is on the include path
`include "timer_output_mode_params.svh"
package timer_output_mode_pkg;
    typedef struct packed {
        logic        write;
        logic        byte_only;
        logic [19:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage : timer_output_mode_pkg

/* File: timer_output_mode_select.sv */
// per-channel timer output mode select and output flip-flops for two timer units
// assumes count events are one-cycle pulses from logic on sys_clk_in
//
// Function
// RULE1: software clears a lone channel's mode bit
// RULE2: for pwm groups, master bit cleared and slave bits set
// RULE3: new mode applies only at next set or reset while output enabled
// RULE4: mode register written as 16 bits, or low byte by itself
// RULE5: reset clears all mode registers to zero
// RULE6: mode 0 toggles the output on the channel's own count event
// RULE7: mode 1 sets on master event, resets on own event
// RULE8: software writes zero to unused upper bits
// RULE9: eight mode bits in unit 0, four in unit 1
// RULE10: masters are even channels, slaves follow them consecutively; the code takes any channel with its applied mode bit clear as a master
// RULE11: polarity inversion applies only in slave output mode
`timescale 1ns/10ps
`default_nettype none
`include "timer_output_mode_params.svh"
module timer_output_mode_select
    import timer_output_mode_pkg::*;
(
    input  wire logic        sys_clk_in,    // peripheral clock
    input  wire logic        reset_n_in,    // sync reset, active low
    input  wire reg_req_t    req_in,        // register access
    input  wire logic [15:0] polarity_in,   // output_polarity_invert_reg, both units
    input  wire logic [11:0] enable_in,     // channel_output_enable_bit, unit1 in [11:8]
    input  wire logic [11:0] event_in,      // channel_count_event pulses
    output logic      [15:0] rdata_out,     // read data, registered
    output logic      [11:0] timer_out      // timer output pins
);
    // per-unit mode storage, 12 flops in total [RULE9]
    logic [7:0]  mode0, next_mode0;
    logic [3:0]  mode1, next_mode1;
    logic [11:0] level, next_level;          // positive-logic output state
    logic [11:0] eff_mode, next_eff_mode;    // mode latched at last set/reset
    logic [11:0] pol, next_pol;              // polarity latched at last set/reset
    logic [15:0] next_rdata;
    logic [11:0] next_timer;
    logic [11:0] master_ev;

    // master event for channel n: nearest lower channel in the same unit with its applied mode bit clear, else the unit's first channel [RULE10]
    function automatic logic [11:0] master_of(input logic [11:0] ev, input logic [11:0] m);
        logic [11:0] r;
        logic        cur;
        r = 12'h000;
        cur = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (i == 0 || i == 8 || !m[i]) begin
                cur = ev[i];
            end
            r[i] = cur;
        end
        return r;
    endfunction : master_of

    always_comb begin
        next_mode0 = mode0;
        next_mode1 = mode1;
        if (req_in.write) begin
            if (req_in.addr == `TOM_UNIT0_ADDR) begin
                next_mode0 = req_in.wdata[7:0]; // [RULE4] upper bits read as zero
            end
            if (req_in.addr == `TOM_UNIT1_ADDR) begin
                next_mode1 = req_in.wdata[3:0]; // [RULE4]
            end
        end
        next_rdata = 16'h0000;
        if (req_in.addr == `TOM_UNIT0_ADDR) begin
            next_rdata = {8'h00, mode0} & `UNIT0_MASK;
        end else if (req_in.addr == `TOM_UNIT1_ADDR) begin
            next_rdata = {12'h000, mode1} & `UNIT1_MASK;
        end
    end

    // chains use the applied mode so a mid-cycle rewrite cannot regroup channels
    assign master_ev = master_of(event_in, eff_mode);

    always_comb begin
        next_level    = level;
        next_eff_mode = eff_mode;
        next_pol      = pol;
        for (int i = 0; i < 12; i++) begin
            logic set_ev;
            logic clr_ev;
            logic mnew;
            set_ev = 1'b0;
            clr_ev = 1'b0;
            mnew = (i < 8) ? mode0[i] : mode1[i-8];
            if (enable_in[i]) begin
                if (!eff_mode[i] && event_in[i]) begin
                    set_ev = 1'b1;
                    next_level[i] = ~level[i]; // [RULE6]
                end else if (eff_mode[i] && master_ev[i] && !event_in[i]) begin
                    set_ev = 1'b1;
                    next_level[i] = 1'b1; // [RULE7]
                end else if (eff_mode[i] && event_in[i]) begin
                    clr_ev = 1'b1;
                    next_level[i] = 1'b0; // [RULE7] own event wins over master
                end
                if (set_ev || clr_ev) begin
                    next_eff_mode[i] = mnew; // [RULE3]
                    next_pol[i] = (i < 8) ? polarity_in[i] : polarity_in[i]; // [RULE11]
                end
            end
        end
        for (int i = 0; i < 12; i++) begin
            next_timer[i] = next_level[i] ^ (next_pol[i] & next_eff_mode[i]); // [RULE11]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            mode0     <= 8'(`TOM_RESET); // [RULE5]
            mode1     <= 4'(`TOM_RESET); // [RULE5]
            level     <= 12'h000;
            eff_mode  <= 12'h000;
            pol       <= 12'h000;
            rdata_out <= 16'h0000;
            timer_out <= 12'h000;
        end else begin
            mode0     <= next_mode0;
            mode1     <= next_mode1;
            level     <= next_level;
            eff_mode  <= next_eff_mode;
            pol       <= next_pol;
            rdata_out <= next_rdata;
            timer_out <= next_timer;
        end
    end

    sequence wr_unit0_s;
        req_in.write && req_in.addr == `TOM_UNIT0_ADDR;
    endsequence

    mode_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE4]
        wr_unit0_s |=> mode0 == $past(req_in.wdata[7:0]))
        else $error("mode register write lost");
    mode_reset_a: assert property (@(posedge sys_clk_in) // [RULE5]
        !reset_n_in |=> mode0 == 8'h00 && mode1 == 4'h0 && timer_out == 12'h000)
        else $error("mode not cleared by reset");
    toggle_out_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE6]
        enable_in[1] && !eff_mode[1] && event_in[1] |=> level[1] != $past(level[1]))
        else $error("master mode did not toggle");
    slave_reset_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE7]
        enable_in[1] && eff_mode[1] && event_in[1] |=> !level[1])
        else $error("slave not reset on own event");
    slave_set_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE7]
        enable_in[1] && eff_mode[1] && event_in[0] && !event_in[1] |=> level[1])
        else $error("slave not set on master event");
    mode_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE3]
        !enable_in[2] |=> eff_mode[2] == $past(eff_mode[2]) && level[2] == $past(level[2]))
        else $error("mode applied while output disabled");
    master_pol_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE11]
        !eff_mode[0] |-> timer_out[0] == level[0])
        else $error("polarity applied in master mode");
    read_back_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE9]
        req_in.addr == `TOM_UNIT1_ADDR && !req_in.write |=> rdata_out == {12'h000, mode1})
        else $error("unit 1 read back wrong");

    // unit 1 and the byte path mirror the unit 0 word write
    sequence wr_unit1_s;
        req_in.write && req_in.addr == `TOM_UNIT1_ADDR;
    endsequence

    sequence wr_byte_s;
        req_in.write && req_in.byte_only && req_in.addr == `TOM_UNIT0_ADDR;
    endsequence

    // a write away from both low addresses must leave every mode bit alone
    sequence wr_stray_s;
        req_in.write && req_in.addr != `TOM_UNIT0_ADDR && req_in.addr != `TOM_UNIT1_ADDR;
    endsequence

    // master event reaches slave channel 1 without its own event
    sequence slave_set_s;
        enable_in[1] && eff_mode[1] && event_in[0] && !event_in[1];
    endsequence

    unit1_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE4]
        wr_unit1_s |=> mode1 == $past(req_in.wdata[3:0]))
        else $error("unit 1 mode write lost");

    byte_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE4]
        wr_byte_s |=> mode0 == $past(req_in.wdata[7:0]))
        else $error("low byte mode write lost");

    stray_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE9]
        wr_stray_s |=> mode0 == $past(mode0) && mode1 == $past(mode1))
        else $error("mode changed by foreign write");

    // inversion is latched with the set, so the pin shows it the cycle after
    slave_pol_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE11]
        slave_set_s |=> timer_out[1] == !$past(polarity_in[1]))
        else $error("slave polarity not applied");

    mode_apply_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE3]
        enable_in[1] && event_in[1] |=> eff_mode[1] == $past(mode0[1]))
        else $error("mode not applied at set or reset");

    unit1_toggle_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE6]
        enable_in[8] && !eff_mode[8] && event_in[8] |=> level[8] != $past(level[8]))
        else $error("unit 1 master did not toggle");

    // unit 1 channel 0 never takes a master from the top of unit 0
    unit_fence_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE10]
        enable_in[8] && eff_mode[8] && event_in[7] && !event_in[8]
        |=> level[8] == $past(level[8]))
        else $error("master chain crossed units");

    out_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE3]
        !enable_in[9] |=> timer_out[9] == $past(timer_out[9]))
        else $error("disabled output moved");

    read_unit0_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [RULE9]
        req_in.addr == `TOM_UNIT0_ADDR && !req_in.write |=> rdata_out == {8'h00, mode0})
        else $error("unit 0 read back wrong");
endmodule : timer_output_mode_select
`default_nettype wire

/* File: count_event_source.sv */
// far-side model: timer channel counters issuing count-complete pulses
// assumes the bench asks for a completion one cycle ahead, on sys_clk_in
`timescale 1ns/10ps
`default_nettype none
module count_event_source (
    input  wire logic        sys_clk_in,  // peripheral clock
    input  wire logic [11:0] fire_in,     // channels whose count completes
    output logic      [11:0] event_out    // one-cycle count-complete pulses
);
    logic [11:0] next_event;
    // bench fires masters on even channels, slaves just above them
    always_comb begin
        next_event = fire_in;
    end
    // registered so each pulse comes one clock after fire_in, like a real counter
    always_ff @(posedge sys_clk_in) begin
        event_out <= next_event;
    end
endmodule : count_event_source
`default_nettype wire

/* File: timer_output_mode_select_tb_top.sv */
// bench for the timer output mode select block
// assumes count events come from count_event_source on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "timer_output_mode_params.svh"
module timer_output_mode_select_tb_top import timer_output_mode_pkg::*; ;
    logic        sys_clk, reset_n;
    reg_req_t    req;
    logic [15:0] pol, rdata;
    logic [11:0] en, fire, ev, tout;
    int          fail_count, compares, cycles;
    localparam logic [19:0] row_addr [5] = '{`TOM_UNIT0_ADDR, `TOM_UNIT0_ADDR,
        `TOM_UNIT1_ADDR, `TOM_UNIT0_ADDR, 20'hf01c0};
    localparam logic [15:0] row_data [5] = '{16'h00a5, 16'h005a, 16'h00ff, 16'hff33, 16'h1234};
    localparam logic        row_byte [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic [15:0] row_exp  [5] = '{16'h00a5, 16'h005a, 16'h000f, 16'h0033, 16'h0000};
    timer_output_mode_select timer_output_mode_select_inst (.sys_clk_in(sys_clk),
        .reset_n_in(reset_n), .req_in(req), .polarity_in(pol), .enable_in(en),
        .event_in(ev), .rdata_out(rdata), .timer_out(tout));
    count_event_source count_event_source_inst (.sys_clk_in(sys_clk), .fire_in(fire),
        .event_out(ev));
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // write then hold the address one more cycle so the read shows the result
    task automatic write_read(input logic [19:0] a, input logic [15:0] d, input logic b,
                              input logic [15:0] exp);
        req = '{write: 1'b1, byte_only: b, addr: a, wdata: d};
        tick();
        req.write = 1'b0;
        tick();
        check(rdata, exp);
    endtask : write_read
    task automatic read(input logic [19:0] a, input logic [15:0] exp);
        req.addr = a;
        tick();
        check(rdata, exp);
    endtask : read
    // event reaches the block one cycle after fire, output one cycle later
    task automatic pulse(input logic [11:0] m, input logic [11:0] exp);
        fire = m;
        tick();
        fire = 12'h000;
        tick();
        check({4'h0, tout}, {4'h0, exp});
    endtask : pulse
    task automatic close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        reset_n = 1'b0;
        req = '0;
        pol = 16'h0000;
        en = 12'h000;
        fire = 12'h000;
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        check({4'h0, tout}, 16'h0000);
        read(`TOM_UNIT0_ADDR, `TOM_RESET);
        read(`TOM_UNIT1_ADDR, `TOM_RESET);
        for (int i = 0; i < 5; i++) begin
            write_read(row_addr[i], row_data[i], row_byte[i], row_exp[i]);
        end
        write_read(`TOM_UNIT0_ADDR, 16'h0000, 1'b0, 16'h0000);
        write_read(`TOM_UNIT1_ADDR, 16'h0000, 1'b0, 16'h0000);
        en = 12'h003;
        pol = 16'h0001;
        pulse(12'h001, 12'h001);
        pulse(12'h001, 12'h000);
        write_read(`TOM_UNIT0_ADDR, 16'h0002, 1'b0, 16'h0002);
        pulse(12'h001, 12'h001);
        pulse(12'h002, 12'h003);
        pulse(12'h001, 12'h002);
        pulse(12'h002, 12'h000);
        pol = 16'h0003;
        pulse(12'h001, 12'h001);
        en = 12'h001;
        pulse(12'h002, 12'h001);
        reset_n = 1'b0;
        tick();
        reset_n = 1'b1;
        check({4'h0, tout}, 16'h0000);
        read(`TOM_UNIT0_ADDR, `TOM_RESET);
        close_out();
    end
endmodule : timer_output_mode_select_tb_top
`default_nettype wire
